// file: core/flsq_top.sv
// mode sequencer of a dual channel flash led driver
// ************************************************************
// Contract
// [RULE_01] flash offers 128 current codes per channel
// [RULE_02] flash start steps through every code
// [RULE_03] option forces both channels to one setting
// [RULE_04] flash timeout clears mode bits
// [RULE_05] torch offers 128 codes from torch settings
// [RULE_06] torch by mode 10 or torch pin
// [RULE_07] torch ramps with programmable step time
// [RULE_08] torch ignores timeout and radio burst
// [RULE_09] host goes standby to ir before torch
// [RULE_10] ir mode uses flash codes, pass condition
// [RULE_11] strobe level gates channels in ir
// [RULE_12] ir switches current without ramp
// [RULE_13] hardware enable low resets everything
// [RULE_14] torch pin defaults to torch function
// [RULE_15] readable fault and event indicator bits
// [RULE_16] radio burst drops flash to torch current
// [RULE_17] sixteen flash timeouts, 10 to 400 ms
// [RULE_18] fault lock until both flag reads
// [RULE_19] mode 00 standby, 11 flash
// ************************************************************
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module flsq_top #(
  parameter int TICK_CYCLES = flsq_pkg::TICK_CYCLES,
  parameter int US_PER_MS   = flsq_pkg::US_PER_MS
) (
  // clock and resets
  input  wire logic                               sys_clk,
  input  wire logic                               reset,
  input  wire logic                               hardware_enable_pin,
  // register port
  input  wire logic [flsq_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic [flsq_pkg::DATA_W-1:0]        reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [flsq_pkg::DATA_W-1:0]        reg_rdata,
  // trigger pins
  input  wire logic                               strobe_pin,
  input  wire logic                               torch_temp_pin,
  input  wire logic                               tx_pin,
  // fault detectors
  input  wire logic                               fault_led_short,
  input  wire logic                               fault_led_hot,
  input  wire logic                               fault_die_hot,
  input  wire logic                               fault_undervolt,
  // current source control
  output logic      [flsq_pkg::CODE_W-1:0]        led1_level,
  output logic      [flsq_pkg::CODE_W-1:0]        led2_level,
  output logic      [1:0]                         led_on,
  output logic                                    pass_mode,
  output logic                                    irq
);
  import flsq_pkg::*;

  if (US_PER_MS < 1 || US_PER_MS * 400 >= (1 << TMO_W)) begin : g_chk
    $error("US_PER_MS out of range for the timeout counter");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0]             mode;
    logic [1:0]             led_en;
    logic                   tpin_en;
    logic                   tpin_temp;
    logic                   same;
    logic [1:0][CODE_W-1:0] flash_code;
    logic [1:0][CODE_W-1:0] torch_code;
    logic [3:0]             tmo_sel;
    logic [2:0]             rate;
    logic [3:0]             flags1;
    logic [1:0]             flags2;
    logic [5:0]             mask;
    logic                   rd1_seen;
    logic                   rd2_seen;
    logic                   lock;
    flsq_state_t            fsm;
    logic [TMO_W-1:0]       tmo_us;
    logic [DATA_W-1:0]      rdata;
    logic [1:0]             led_on;
    logic                   pass_mode;
    logic                   irq;
  } flsq_top_state_t;

  flsq_top_state_t        s;
  flsq_top_state_t        next_s;
  logic                   rst;
  logic                   expire;
  logic [1:0][CODE_W-1:0] tgt;
  logic                   imm;
  logic [2:0]             tgt_rate;

  flsq_ramp_if rif ();

  flsq_ramper #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_ramper (
    .sys_clk (sys_clk),
    .rst     (rst),
    .rif     (rif)
  );

  assign rst = reset | ~hardware_enable_pin;   // [RULE_13]

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [3:0]             set1;
    logic [1:0]             set2;
    logic [3:0]             clr1;
    logic [1:0]             clr2;
    logic                   hw_torch;
    logic [1:0][CODE_W-1:0] fl;
    logic [1:0][CODE_W-1:0] tr;
    logic [TMO_W-1:0]       limit;
    set1 = '0;
    set2 = '0;
    clr1 = '0;
    clr2 = '0;
    hw_torch = 1'b0;
    fl = '0;
    tr = '0;
    limit = '0;
    next_s = s;
    next_s.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_ENABLE: next_s.rdata = {2'h0, s.tpin_temp, s.tpin_en, s.led_en, s.mode};
        REG_FLASH1: next_s.rdata = {s.same, s.flash_code[0]};
        REG_FLASH2: next_s.rdata = {1'b0, s.flash_code[1]};
        REG_TORCH1: next_s.rdata = {1'b0, s.torch_code[0]};
        REG_TORCH2: next_s.rdata = {1'b0, s.torch_code[1]};
        REG_TIMING: next_s.rdata = {1'b0, s.rate, s.tmo_sel};
        REG_FLAGS1: begin
          next_s.rdata = {4'h0, s.flags1};   // [RULE_15]
          next_s.rd1_seen = 1'b1;
        end
        REG_FLAGS2: begin
          next_s.rdata = {6'h00, s.flags2};
          next_s.rd2_seen = 1'b1;
        end
        REG_MASK:   next_s.rdata = {2'h0, s.mask};
        REG_STATUS: next_s.rdata = {2'h0, rif.settled, s.lock, s.fsm};
        default:    next_s.rdata = '0;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        REG_ENABLE: begin
          if (!s.lock) begin
            next_s.mode = reg_wdata[1:0];   // [RULE_18]
          end
          next_s.led_en    = reg_wdata[EN_LED2:EN_LED1];
          next_s.tpin_en   = reg_wdata[EN_TPIN];
          next_s.tpin_temp = reg_wdata[EN_TEMP];
        end
        REG_FLASH1: begin
          next_s.flash_code[0] = reg_wdata[CODE_W-1:0];   // [RULE_01]
          next_s.same = reg_wdata[SAME_BIT];
        end
        REG_FLASH2: next_s.flash_code[1] = reg_wdata[CODE_W-1:0];
        REG_TORCH1: next_s.torch_code[0] = reg_wdata[CODE_W-1:0];   // [RULE_05]
        REG_TORCH2: next_s.torch_code[1] = reg_wdata[CODE_W-1:0];
        REG_TIMING: begin
          next_s.tmo_sel = reg_wdata[3:0];
          next_s.rate = reg_wdata[TIM_RATE+2:TIM_RATE];
        end
        REG_FLAGS1: clr1 = reg_wdata[3:0];
        REG_FLAGS2: clr2 = reg_wdata[1:0];
        REG_MASK:   next_s.mask = reg_wdata[5:0];
        default: ;
      endcase
    end
    // flash timeout runs only in flash; torch never sees it
    limit = TMO_W'(flsq_timeout_ms(s.tmo_sel) * US_PER_MS);   // [RULE_17]
    expire = (s.fsm == ST_FLASH) && rif.tick_us && (s.tmo_us >= limit - 19'h00001);
    if (s.fsm != ST_FLASH) begin
      next_s.tmo_us = '0;   // [RULE_08]
    end else if (rif.tick_us) begin
      next_s.tmo_us = s.tmo_us + 19'h00001;
    end
    if (expire) begin
      set1[FL1_TMO] = 1'b1;
      next_s.mode = MODE_STBY;   // [RULE_04]
    end
    set1[FL1_TX]    = (s.fsm == ST_FLASH) && tx_pin;
    set1[FL1_DIE]   = fault_die_hot;
    set1[FL1_UVLO]  = fault_undervolt;
    set2[FL2_SHORT]  = fault_led_short;
    set2[FL2_LEDHOT] = fault_led_hot;
    if (fault_die_hot || fault_undervolt || |set2) begin
      next_s.mode = MODE_STBY;   // [RULE_18]
      next_s.lock = 1'b1;
      next_s.rd1_seen = 1'b0;
      next_s.rd2_seen = 1'b0;
    end else if (s.lock && s.rd1_seen && s.rd2_seen) begin
      next_s.lock = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    next_s.flags1 = (s.flags1 & ~clr1) | set1;   // [RULE_15]
    next_s.flags2 = (s.flags2 & ~clr2) | set2;
    hw_torch = s.tpin_en && !s.tpin_temp && torch_temp_pin;   // [RULE_14]
    if (s.lock) begin
      next_s.fsm = ST_STBY;
    end else begin
      unique case (flsq_mode_t'(s.mode))   // [RULE_19]
        MODE_FLASH: next_s.fsm = ST_FLASH;
        MODE_TORCH: next_s.fsm = ST_TORCH;   // [RULE_06]
        MODE_IR:    next_s.fsm = ST_IR;
        MODE_STBY:  next_s.fsm = hw_torch ? ST_TORCH : ST_STBY;   // [RULE_06]
      endcase
    end
    fl[0] = s.flash_code[0];
    fl[1] = s.same ? s.flash_code[0] : s.flash_code[1];   // [RULE_03]
    tr[0] = s.torch_code[0];
    tr[1] = s.same ? s.torch_code[0] : s.torch_code[1];   // [RULE_03]
    tgt = '0;
    imm = 1'b1;
    tgt_rate = FLASH_RATE;
    unique case (s.fsm)
      ST_FLASH: begin
        tgt = tx_pin ? tr : fl;   // [RULE_16]
        imm = 1'b0;   // [RULE_02]
      end
      ST_TORCH: begin
        tgt = tr;   // [RULE_08]
        imm = 1'b0;
        tgt_rate = s.rate;   // [RULE_07]
      end
      ST_IR:    tgt = strobe_pin ? fl : '0;   // [RULE_11] [RULE_12]
      ST_STBY:  tgt = '0;
    endcase
    for (int ch = 0; ch < 2; ch++) begin
      if (!s.led_en[ch]) begin
        tgt[ch] = '0;
      end
      next_s.led_on[ch] = s.led_en[ch] && (s.fsm != ST_STBY)
        && (s.fsm != ST_IR || strobe_pin);   // [RULE_11]
    end
    next_s.pass_mode = (s.fsm == ST_IR);   // [RULE_10]
    next_s.irq = |({s.flags2, s.flags1} & s.mask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;   // [RULE_13]
      s.fsm <= ST_STBY;
      s.led_en <= RST_LED_EN;
      s.tmo_sel <= RST_TMO;
      s.rate <= RST_RATE;
    end else begin
      s <= next_s;
    end
  end

  assign rif.target    = tgt;
  assign rif.immediate = imm;
  assign rif.rate      = tgt_rate;
  assign reg_rdata  = s.rdata;
  assign led1_level = rif.level[0];
  assign led2_level = rif.level[1];
  assign led_on     = s.led_on;
  assign pass_mode  = s.pass_mode;
  assign irq        = s.irq;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_flash_expiry;
    s.fsm == ST_FLASH ##0 expire;
  endsequence

  a_timeout_clear: assert property (s_flash_expiry |=> // [RULE_04]
    s.mode == 2'h0 && s.flags1[FL1_TMO] ##1 s.fsm == ST_STBY)
    else $error("flash timeout did not clear the mode");
  a_torch_holds: assert property (s.fsm == ST_TORCH && s.mode == 2'h2 && !s.lock // [RULE_08]
    && !(reg_wr && reg_addr == REG_ENABLE) |=> s.fsm == ST_TORCH && !expire)
    else $error("torch left without a mode change");
  a_ir_gate_on: assert property (s.fsm == ST_IR && strobe_pin && s.led_en[0] // [RULE_11]
    |=> led_on[0] && pass_mode)
    else $error("ir strobe high did not enable channel");
  a_ir_gate_off: assert property (s.fsm == ST_IR && !strobe_pin |=> led_on == 2'h0) // [RULE_11]
    else $error("ir strobe low left a channel on");
  a_ir_no_ramp: assert property (s.fsm == ST_IR && strobe_pin && s.led_en[0] // [RULE_12]
    |=> led1_level == $past(s.flash_code[0]))
    else $error("ir current did not switch at once");
  a_tx_to_torch: assert property (s.fsm == ST_FLASH && tx_pin && s.led_en[0] // [RULE_16]
    |-> tgt[0] == s.torch_code[0])
    else $error("radio burst did not select torch current");
  a_same_current: assert property (s.same && s.led_en == 2'h3 |-> tgt[1] == tgt[0]) // [RULE_03]
    else $error("channels differ with shared setting");
  a_fault_lock: assert property (s.lock |=> s.fsm == ST_STBY) // [RULE_18]
    else $error("device left standby while locked");
  a_torch_pin: assert property (s.mode == 2'h0 && !s.lock && s.tpin_en && !s.tpin_temp // [RULE_06]
    && torch_temp_pin |=> s.fsm == ST_TORCH)
    else $error("torch pin did not start torch");
  a_hardware_enable_pin_reset: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_13]
    !hardware_enable_pin |=> s.mode == 2'h0 && s.mask == 6'h00 && !s.tpin_temp)
    else $error("hardware enable low did not reset registers");

endmodule
`default_nettype wire

// file: shared/flsq_pkg.sv
// constants, register map and helpers of the flash led mode sequencer
package flsq_pkg;

  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int CODE_W        = 7;     // 128 current codes per channel
  localparam int ADDR_W        = 4;
  localparam int DATA_W        = 8;
  localparam int TMO_W         = 19;
  localparam int STEP_W        = 12;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int US_PER_MS     = 1000;
  localparam logic [2:0] FLASH_RATE = 3'h0;

  // ************************************************************
  // register offsets and reset values
  // ************************************************************
  localparam logic [ADDR_W-1:0] REG_ENABLE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_FLASH1 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FLASH2 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_TORCH1 = 4'h3;
  localparam logic [ADDR_W-1:0] REG_TORCH2 = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TIMING = 4'h5;
  localparam logic [ADDR_W-1:0] REG_FLAGS1 = 4'h6;
  localparam logic [ADDR_W-1:0] REG_FLAGS2 = 4'h7;
  localparam logic [ADDR_W-1:0] REG_MASK   = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h9;

  localparam logic [1:0]        RST_LED_EN = 2'h3;
  localparam logic [3:0]        RST_TMO    = 4'ha;
  localparam logic [2:0]        RST_RATE   = 3'h1;
  localparam logic [CODE_W-1:0] RST_CODE   = 7'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int EN_LED1    = 2;
  localparam int EN_LED2    = 3;
  localparam int EN_TPIN    = 4;
  localparam int EN_TEMP    = 5;
  localparam int SAME_BIT   = 7;
  localparam int TIM_RATE   = 4;
  localparam int FL1_TMO    = 0;
  localparam int FL1_DIE    = 1;
  localparam int FL1_UVLO   = 2;
  localparam int FL1_TX     = 3;
  localparam int FL2_SHORT  = 0;
  localparam int FL2_LEDHOT = 1;

  // ************************************************************
  // modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_STBY  = 2'h0,
    MODE_IR    = 2'h1,
    MODE_TORCH = 2'h2,
    MODE_FLASH = 2'h3
  } flsq_mode_t;

  typedef enum logic [3:0] {
    ST_STBY  = 4'h1,
    ST_IR    = 4'h2,
    ST_TORCH = 4'h4,
    ST_FLASH = 4'h8
  } flsq_state_t;

  // flash timeout in ms for each of the 16 selector codes
  function automatic int flsq_timeout_ms(input logic [3:0] sel);
    int t;
    t = (sel < 4'ha) ? (int'(sel) + 1) * 10 : (int'(sel) - 7) * 50;
    return t;
  endfunction

  // microsecond ticks per current step for each ramp rate code
  function automatic logic [STEP_W-1:0] flsq_step_ticks(input logic [2:0] rate);
    logic [STEP_W-1:0] t;
    t = (rate == 3'h0) ? 12'h001 : (12'h020 << (rate - 3'h1));
    return t;
  endfunction

endpackage

// file: shared/flsq_ramp_if.sv
// handshake between mode control and the current ramp engine
`timescale 1ns/100ps
`default_nettype none
interface flsq_ramp_if;
  logic [1:0][flsq_pkg::CODE_W-1:0] target;
  logic [2:0]                       rate;
  logic                             immediate;
  logic                             tick_us;
  logic [1:0][flsq_pkg::CODE_W-1:0] level;
  logic                             settled;

  modport ctrl (output target, output rate, output immediate,
                input tick_us, input level, input settled);
  modport ramp (input target, input rate, input immediate,
                output tick_us, output level, output settled);
endinterface
`default_nettype wire

// file: core/flsq_ramper.sv
// microsecond divider and per-channel current ramp
`timescale 1ns/100ps
`default_nettype none
module flsq_ramper #(
  parameter int TICK_CYCLES = flsq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst,
  // ramp control
  flsq_ramp_if.ramp   rif
);
  import flsq_pkg::*;

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [TW-1:0]          tick_cnt;
    logic                   tick;
    logic [STEP_W-1:0]      step_cnt;
    logic [1:0][CODE_W-1:0] level;
  } flsq_ramp_state_t;

  flsq_ramp_state_t s;
  flsq_ramp_state_t next_s;

  always_comb begin
    logic step_due;
    step_due = 1'b0;
    next_s = s;
    next_s.tick = 1'b0;
    if (s.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + TW'(1);
    end
    if (s.tick) begin
      if (s.step_cnt >= flsq_step_ticks(rif.rate) - 12'h001) begin
        next_s.step_cnt = '0;
        step_due = 1'b1;
      end else begin
        next_s.step_cnt = s.step_cnt + 12'h001;
      end
    end
    for (int ch = 0; ch < 2; ch++) begin
      if (rif.immediate) begin
        next_s.level[ch] = rif.target[ch];   // [RULE_12]
      end else if (step_due && s.level[ch] < rif.target[ch]) begin
        next_s.level[ch] = s.level[ch] + 7'h01;   // [RULE_02] [RULE_07]
      end else if (step_due && s.level[ch] > rif.target[ch]) begin
        next_s.level[ch] = s.level[ch] - 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rif.tick_us = s.tick;
  assign rif.level   = s.level;
  assign rif.settled = (s.level == rif.target);

  // a ramped channel never moves by more than one code per cycle
  a_ramp_single_step: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_02]
    !rif.immediate |=> (s.level[0] == $past(s.level[0])
      || s.level[0] == $past(s.level[0]) + 7'h01
      || s.level[0] == $past(s.level[0]) - 7'h01))
    else $error("ramped level jumped more than one code");

endmodule
`default_nettype wire

// file: verification/flsq_host.sv
// host model: register port master and trigger pin driver
`timescale 1ns/100ps
`default_nettype none
module flsq_host (
  // clock
  input  wire logic                        sys_clk,
  // register port
  output var logic [flsq_pkg::ADDR_W-1:0]  reg_addr,
  output var logic [flsq_pkg::DATA_W-1:0]  reg_wdata,
  output var logic                         reg_wr,
  output var logic                         reg_rd,
  input  wire logic [flsq_pkg::DATA_W-1:0] reg_rdata,
  // trigger pins
  output var logic                         strobe_pin,
  output var logic                         torch_temp_pin,
  output var logic                         tx_pin
);
  import flsq_pkg::*;
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {strobe_pin, torch_temp_pin, tx_pin} = 3'h0;
  end
  // ************************
  // bus cycles
  // ************************
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dv);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= dv;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~dv;  // released data must never look like the last value
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dv);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    #1;
    dv = reg_rdata;
  endtask
  // ************************
  // pins and sequences
  // ************************
  // pulse timing of the ir gate is owned here, the device only follows the level
  task automatic pins(input logic s, input logic t, input logic x);
    @(posedge sys_clk);
    strobe_pin     <= s;
    torch_temp_pin <= t;
    tx_pin         <= x;
  endtask
  // analog side needs settling in ir before torch is selected
  task automatic torch_on(input logic [DATA_W-1:0] en, input int settle);
    wr(REG_ENABLE, {en[7:2], MODE_IR});
    repeat (settle) @(posedge sys_clk);
    wr(REG_ENABLE, {en[7:2], MODE_TORCH});
  endtask
endmodule
`default_nettype wire

// file: verification/flsq_tb_top.sv
// self-checking bench of the flash led mode sequencer
`timescale 1ns/100ps
`default_nettype none
module flsq_tb_top;
  import flsq_pkg::*;
  localparam int TK = 4;
  localparam int UM = 2;
  logic              sys_clk;
  logic              reset;
  logic              hw_en;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              strobe_pin;
  logic              torch_temp_pin;
  logic              tx_pin;
  logic [3:0]        flt;
  logic [CODE_W-1:0] led1_level;
  logic [CODE_W-1:0] led2_level;
  logic [CODE_W-1:0] prev1;
  logic [1:0]        led_on;
  logic              pass_mode;
  logic              irq;
  logic              watch;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] e1;
  logic [DATA_W-1:0] e2;
  int                n_mismatch = 0;
  int                checks = 0;
  int                cyc = 0;
  int                t0;
  int                t;

  flsq_host i_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                    .strobe_pin, .torch_temp_pin, .tx_pin);
  flsq_top #(.TICK_CYCLES(TK), .US_PER_MS(UM)) i_dut (
    .sys_clk, .reset, .hardware_enable_pin(hw_en),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strobe_pin, .torch_temp_pin, .tx_pin,
    .fault_led_short(flt[0]), .fault_led_hot(flt[1]),
    .fault_die_hot(flt[2]), .fault_undervolt(flt[3]),
    .led1_level, .led2_level, .led_on, .pass_mode, .irq);

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ************************
  // checking helpers
  // ************************
  always @(posedge sys_clk) begin
    cyc   <= cyc + 1;
    prev1 <= led1_level;
    if (watch && led1_level !== prev1 && led1_level !== prev1 + 7'h01) begin
      n_mismatch++;
      $display("ERROR ramp_step expected %0h seen %0h", prev1 + 7'h01, led1_level);
    end
  end
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic chk_rng(input string w, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("ERROR %s expected %0d..%0d seen %0d", w, lo, hi, g);
    end
  endtask
  task automatic rdchk(input string w, input logic [3:0] a, input logic [7:0] m,
                       input logic [7:0] e);
    i_host.rd(a, d);
    chk(w, e, d & m);
  endtask
  task automatic wait_lvl(input logic [CODE_W-1:0] v, input int lim, output int tt);
    for (int n = 0; n < lim && led1_level !== v; n++) begin
      @(posedge sys_clk);
      #1;
    end
    tt = cyc;
    chk("led1_level", {1'h0, v}, {1'h0, led1_level});
  endtask
  task automatic wait_off(output int tt);
    for (int n = 0; n < 4000 && led_on !== 2'h0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    tt = cyc;
  endtask
  task automatic fault_pulse(input int i);
    @(posedge sys_clk);
    flt[i] <= 1'h1;
    @(posedge sys_clk);
    flt[i] <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    $display("ERROR watchdog expected end seen timeout");
    conclude();
  end
  // ************************
  // tests
  // ************************
  initial begin
    reset = 1'h1;
    hw_en = 1'h1;
    flt   = 4'h0;
    watch = 1'h0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'h0;
    rdchk("enable", REG_ENABLE, 8'hff, 8'h0c);
    rdchk("timing", REG_TIMING, 8'hff, 8'h1a);
    rdchk("unmapped", 4'hf, 8'hff, 8'h00);
    for (int m = 3; m >= 0; m--) begin
      i_host.wr(REG_ENABLE, 8'(m));
      rdchk("status", REG_STATUS, 8'h0f, 8'h01 << m);
    end
    $display("test reset_modes done");
    i_host.wr(REG_FLASH1, 8'h20);
    i_host.wr(REG_FLASH2, 8'h10);
    i_host.wr(REG_ENABLE, 8'h0d);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("pass_mode", 8'h01, {7'h00, pass_mode});
    chk("led_on", 8'h00, {6'h00, led_on});
    i_host.pins(1'h1, 1'h0, 1'h0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("led1_level", 8'h20, {1'h0, led1_level});
    chk("led2_level", 8'h10, {1'h0, led2_level});
    chk("led_on", 8'h03, {6'h00, led_on});
    i_host.pins(1'h0, 1'h0, 1'h0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("led1_level", 8'h00, {1'h0, led1_level});
    chk("led_on", 8'h00, {6'h00, led_on});
    $display("test ir done");
    i_host.wr(REG_FLASH1, 8'hff);
    i_host.wr(REG_FLASH2, 8'h00);
    i_host.wr(REG_TORCH1, 8'h03);
    i_host.wr(REG_TIMING, 8'h0f);
    t0 = cyc;
    watch = 1'h1;
    i_host.wr(REG_ENABLE, 8'h0f);
    wait_lvl(7'h7f, 700, t);
    watch = 1'h0;
    chk_rng("ramp_time", 127 * TK, 127 * TK + 24, t - t0);
    chk("led2_level", 8'h7f, {1'h0, led2_level});
    i_host.pins(1'h0, 1'h0, 1'h1);
    wait_lvl(7'h03, 700, t);
    chk("led2_level", 8'h03, {1'h0, led2_level});
    i_host.pins(1'h0, 1'h0, 1'h0);
    wait_lvl(7'h7f, 700, t);
    wait_off(t);
    chk_rng("timeout", 400 * UM * TK, 400 * UM * TK + 16, t - t0);
    rdchk("mode", REG_ENABLE, 8'h03, 8'h00);
    rdchk("flags1", REG_FLAGS1, 8'hff, 8'h09);
    i_host.wr(REG_FLAGS1, 8'h09);
    rdchk("flags1", REG_FLAGS1, 8'hff, 8'h00);
    i_host.wr(REG_TIMING, 8'h10);
    t0 = cyc;
    i_host.wr(REG_ENABLE, 8'h0f);
    repeat (5) @(posedge sys_clk);
    wait_off(t);
    chk_rng("timeout", 10 * UM * TK, 10 * UM * TK + 16, t - t0);
    i_host.wr(REG_FLAGS1, 8'h01);
    $display("test flash done");
    i_host.wr(REG_FLASH1, 8'h20);
    i_host.wr(REG_TORCH1, 8'h04);
    i_host.wr(REG_TORCH2, 8'h02);
    i_host.torch_on(8'h0c, 3 * UM * TK);
    watch = 1'h1;
    wait_lvl(7'h01, 300, t0);
    wait_lvl(7'h02, 300, t);
    chk_rng("step_time", 32 * TK - 2, 32 * TK + 2, t - t0);
    wait_lvl(7'h04, 400, t);
    watch = 1'h0;
    chk("led2_level", 8'h02, {1'h0, led2_level});
    i_host.pins(1'h0, 1'h0, 1'h1);
    repeat (100) @(posedge sys_clk);
    #1;
    chk("led1_level", 8'h04, {1'h0, led1_level});
    rdchk("flags1", REG_FLAGS1, 8'hff, 8'h00);
    i_host.wr(REG_ENABLE, 8'h1c);
    i_host.pins(1'h0, 1'h1, 1'h0);
    repeat (3) @(posedge sys_clk);
    rdchk("status", REG_STATUS, 8'h0f, 8'h04);
    i_host.wr(REG_ENABLE, 8'h3c);
    repeat (3) @(posedge sys_clk);
    rdchk("status", REG_STATUS, 8'h0f, 8'h01);
    i_host.pins(1'h0, 1'h0, 1'h0);
    $display("test torch done");
    i_host.wr(REG_ENABLE, 8'h0e);
    fault_pulse(2);
    chk("irq", 8'h00, {7'h00, irq});
    rdchk("mode", REG_ENABLE, 8'h03, 8'h00);
    rdchk("flags1", REG_FLAGS1, 8'hff, 8'h02);
    i_host.wr(REG_ENABLE, 8'h0e);
    rdchk("status", REG_STATUS, 8'h1f, 8'h11);
    rdchk("flags2", REG_FLAGS2, 8'hff, 8'h00);
    i_host.wr(REG_ENABLE, 8'h0e);
    rdchk("status", REG_STATUS, 8'h1f, 8'h04);
    i_host.wr(REG_MASK, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    i_host.wr(REG_FLAGS1, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    for (int i = 0; i < 4; i++) begin
      e1 = (i == 2) ? 8'h02 : (i == 3) ? 8'h04 : 8'h00;
      e2 = (i < 2) ? 8'h01 << i : 8'h00;
      fault_pulse(i);
      rdchk("flags1", REG_FLAGS1, 8'hff, e1);
      rdchk("flags2", REG_FLAGS2, 8'hff, e2);
      i_host.wr(REG_FLAGS1, 8'hff);
      i_host.wr(REG_FLAGS2, 8'hff);
    end
    $display("test faults done");
    i_host.wr(REG_MASK, 8'h3f);
    @(posedge sys_clk);
    hw_en <= 1'h0;
    @(posedge sys_clk);
    hw_en <= 1'h1;
    rdchk("flash1", REG_FLASH1, 8'hff, 8'h00);
    rdchk("mask", REG_MASK, 8'hff, 8'h00);
    rdchk("enable", REG_ENABLE, 8'hff, 8'h0c);
    $display("test hw_enable done");
    conclude();
  end
endmodule
`default_nettype wire
